// ==== common/can_csr_pkg.sv ====
// Purpose: Shared constants for the CAN control and status register block.
// Assumes: 16-bit register window, byte addresses, word aligned registers.
// Notes: Offsets are full 16-bit byte addresses inside the controller window.

package can_csr_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] WINDOW_BASE = 16'hef00;
  localparam logic [7:0] WINDOW_BYTES_M1 = 8'hff;
  localparam logic [15:0] ADDR_CONTROL_AND_STATUS = 16'hef00;
  localparam logic [15:0] ADDR_INTERRUPT_CAUSE = 16'hef02;
  localparam logic [15:0] ADDR_BIT_TIMING = 16'hef04;
  localparam logic [15:0] ADDR_GLOBAL_MASK_STANDARD = 16'hef06;
  localparam logic [15:0] ADDR_GLOBAL_MASK_EXTENDED = 16'hef08;
  localparam logic [15:0] ADDR_FINAL_OBJECT_MASK = 16'hef0c;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ==========================================================================
  // Control and status fields
  localparam int BIT_INIT = 0;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 1;
  localparam int BIT_STATUS_CHANGE_IRQ_ENABLE = 2;
  localparam int BIT_ERROR_IRQ_ENABLE = 3;
  localparam int BIT_TIMING_WRITE_UNLOCK = 6;
  localparam int BIT_TEST = 7;
  localparam int LEC_LSB = 8;
  localparam int BIT_TX_SUCCESS = 11;
  localparam int BIT_RX_SUCCESS = 12;
  localparam int BIT_ERROR_WARNING = 14;
  localparam int BIT_BUS_OFF = 15;
  localparam logic [15:0] CSR_RESET = 16'h0001;
  localparam logic [15:0] BIT_TIMING_RESET = 16'h0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // ==========================================================================
  // Error codes, interrupt identifiers and counts
  localparam logic [2:0] LEC_NONE = 3'h0;
  localparam logic [2:0] LEC_STUFF = 3'h1;
  localparam logic [2:0] LEC_FORM = 3'h2;
  localparam logic [2:0] LEC_ACK = 3'h3;
  localparam logic [2:0] LEC_BIT1 = 3'h4;
  localparam logic [2:0] LEC_BIT0 = 3'h5;
  localparam logic [2:0] LEC_CRC = 3'h6;
  localparam logic [7:0] IRQ_ID_IDLE = 8'h00;
  localparam logic [7:0] IRQ_ID_STATUS = 8'h01;
  localparam logic [7:0] IRQ_ID_LAST_OBJECT = 8'h02;
  localparam logic [7:0] IRQ_ID_OBJECT_BASE = 8'h02;
  localparam int MSG_OBJECTS = 15;
  localparam logic [3:0] RECESSIVE_RUN = 4'hb;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [7:0] WARNING_LIMIT = 8'h60;
  localparam int EVENT_WIDTH = 4;
  localparam int EVENT_DEPTH = 2;

endpackage

// ==== testbench/can_control_status_regs_monitor.sv ====
// Purpose: Port checker for the CAN control and status block.
// Assumes: One clock, asynchronous active low reset.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ns
`default_nettype none

module can_control_status_regs_monitor (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [1:0] i_byte_en,
  input wire logic i_bus_off,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_init,
  input wire logic o_may_start,
  input wire logic o_test_bit,
  input wire logic [15:0] o_bit_timing,
  input wire logic [15:0] o_mask_standard
);
  import can_csr_pkg::*;
  // ==========
  // Properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_read_answer: assert property (
    (i_cs && i_rd && i_addr[15:8] == 8'hef) |=> o_rvalid) else $error("Read got no answer.");
  a_answer_cause: assert property (
    o_rvalid |-> $past(i_cs && i_rd)) else $error("Answer without a read.");
  a_idle_rdata: assert property (
    !o_rvalid |-> o_rdata == 16'h0000) else $error("Read data not zero when idle.");
  a_busoff_init: assert property (
    $rose(i_bus_off) |-> ##[1:2] o_init) else $error("Bus-off did not set init.");
  a_init_blocks: assert property (
    o_init |-> !o_may_start) else $error("Transfer allowed during init.");
  a_init_fall_cpu: assert property (
    $fell(o_init) |-> $past(i_cs && i_wr && i_byte_en[0] && i_addr == ADDR_CONTROL_AND_STATUS))
    else $error("Init cleared without a write.");
  a_timing_hold: assert property (
    !(i_cs && i_wr && i_addr[15:1] == ADDR_BIT_TIMING[15:1]) |=> $stable(o_bit_timing))
    else $error("Bit timing changed without a write.");
  a_mask_hold: assert property (
    !(i_cs && i_wr) |=> $stable(o_mask_standard)) else $error("Mask changed without a write.");
  a_test_write: assert property (
    $changed(o_test_bit) |-> $past(i_cs && i_wr && i_byte_en[0]))
    else $error("Test bit changed without a write.");
endmodule // can_control_status_regs_monitor

`default_nettype wire

// ==== testbench/can_control_status_regs_tb_top.sv ====
// Purpose: Self-checking bench for the CAN control and status block.
// Assumes: 10 MHz clock, reads scored from a queue of expected words.
// Notes: Message object pending inputs are tied off.
`timescale 1ns/1ns
`default_nettype none

module can_control_status_regs_tb_top;
  import can_csr_pkg::*;
  logic core_clk = 0, arst_n = 0, cs = 0, rd = 0, wr = 0, bus_off = 0, saw_full = 0;
  logic [15:0] addr = 16'h0, wdata = 16'h0, rdata, bt, v, bit_timing, mask_std;
  logic [1:0] byte_en = 2'h0;
  logic [7:0] tx_err = 8'h0, rx_err = 8'h0, st;
  logic [31:0] mask_ext, mask_fin;
  logic evt_valid, evt_ready, strobe, bit_val, stuff, rvalid, irq, init, may_start, test_bit;
  logic [3:0] evt_data;
  logic [15:0] exp_q[$];
  int fail_count = 0, num_checks = 0;
  initial forever #50 core_clk = ~core_clk;
  can_control_status_regs i_can_control_status_regs (.i_core_clk(core_clk), .i_arst_n(arst_n),
    .i_cs(cs), .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_byte_en(byte_en), .i_wdata(wdata),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_evt_valid(evt_valid), .o_evt_ready(evt_ready),
    .i_evt_data(evt_data), .i_bit_strobe(strobe), .i_bit_value(bit_val),
    .i_stuff_region(stuff), .i_tx_err_count(tx_err), .i_rx_err_count(rx_err),
    .i_bus_off(bus_off), .i_msg_irq_pending(15'h0), .o_irq(irq), .o_init(init),
    .o_may_start(may_start), .o_test_bit(test_bit), .o_bit_timing(bit_timing),
    .o_mask_standard(mask_std), .o_mask_extended(mask_ext), .o_mask_final(mask_fin));
  can_engine_model i_can_engine_model (.i_core_clk(core_clk), .i_evt_ready(evt_ready),
    .o_evt_valid(evt_valid), .o_evt_data(evt_data), .o_bit_strobe(strobe),
    .o_bit_value(bit_val), .o_stuff_region(stuff));
  // ==========
  // Tasks
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t port %b expected %b", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [1:0] be,
                     input logic [15:0] d);
    @(posedge core_clk);
    cs <= 1'b1;
    rd <= ~w;
    wr <= w;
    addr <= a;
    byte_en <= be;
    wdata <= d;
    @(posedge core_clk);
    cs <= 1'b0;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rdx(input logic [15:0] a, input logic [1:0] be, input logic [15:0] e);
    acc(1'b0, a, be, 16'h0);
    exp_q.push_back(e);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (evt_ready === 1'b0) saw_full <= 1'b1;
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("FAIL %0t unexpected read answer", $time);
      end else cmp16(rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("FAIL %0t run did not finish", $time);
    test_done();
  end
  // ==========
  // Scenarios
  initial begin
    void'($urandom(90));
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    rdx(16'hef00, 2'h3, CSR_RESET);
    chk(init, 1'b1);
    chk(irq, 1'b0);
    acc(1'b1, 16'hef00, 2'h1, 16'h007f);
    rdx(16'hef00, 2'h3, 16'h004f);
    chk(test_bit, 1'b0);
    bt = 16'($urandom);
    acc(1'b1, 16'hef04, 2'h3, bt);
    rdx(16'hef04, 2'h3, bt);
    acc(1'b1, 16'hef00, 2'h1, 16'h000f);
    acc(1'b1, 16'hef04, 2'h3, ~bt);
    chk(bit_timing === bt, 1'b1);
    rdx(16'hef04, 2'h3, 16'h0);
    for (int i = 3; i < 8; i++) begin
      v = 16'($urandom);
      acc(1'b1, 16'hef00 + 16'(2 * i), 2'h3, v);
      rdx(16'hef00 + 16'(2 * i), 2'h3, v);
    end
    acc(1'b1, 16'hef0e, 2'h1, 16'hffc3);
    rdx(16'hef0e, 2'h3, {v[15:8], 8'hc3});
    rdx(16'hef0e, 2'h2, {v[15:8], 8'h00});
    chk(mask_fin[31:16] === {v[15:8], 8'hc3}, 1'b1);
    acc(1'b1, 16'hef1e, 2'h3, 16'hffff);
    rdx(16'hef1e, 2'h3, 16'h0);
    acc(1'b1, 16'hef00, 2'h1, 16'h000e);
    chk(init, 1'b0);
    for (int c = 0; c < 7; c++) begin
      i_can_engine_model.burst(1, {1'b1, 3'(c)});
      st = 8'h08 | 8'(c);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'b1);
      rdx(16'hef00, 2'h1, 16'h000e);
      chk(irq, 1'b1);
      rdx(16'hef00, 2'h2, {st, 8'h00});
      chk(irq, 1'b0);
    end
    i_can_engine_model.burst(1, 4'h0);
    repeat (3) @(posedge core_clk);
    rdx(16'hef00, 2'h2, 16'h1800);
    acc(1'b1, 16'hef00, 2'h2, 16'h0700);
    chk(irq, 1'b0);
    rdx(16'hef00, 2'h2, 16'h0700);
    i_can_engine_model.bits(5, 1'b0, 1'b1);
    rdx(16'hef00, 2'h2, 16'h0700);
    i_can_engine_model.bits(1, 1'b0, 1'b1);
    repeat (2) @(posedge core_clk);
    rdx(16'hef00, 2'h2, 16'h0100);
    tx_err <= 8'h5f;
    repeat (3) @(posedge core_clk);
    rdx(16'hef00, 2'h2, 16'h0100);
    tx_err <= 8'h60;
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b1);
    rdx(16'hef00, 2'h2, 16'h4100);
    rx_err <= 8'h60;
    tx_err <= 8'h0;
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0);
    rdx(16'hef00, 2'h2, 16'h4100);
    rx_err <= 8'h0;
    repeat (3) @(posedge core_clk);
    rdx(16'hef00, 2'h2, 16'h0100);
    bus_off <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(init, 1'b1);
    rdx(16'hef00, 2'h2, 16'h8100);
    rdx(16'hef00, 2'h1, 16'h000f);
    acc(1'b1, 16'hef00, 2'h1, 16'h000e);
    i_can_engine_model.bits(11, 1'b1, 1'b0);
    repeat (2) @(posedge core_clk);
    rdx(16'hef00, 2'h2, 16'h8500);
    chk(may_start, 1'b0);
    bus_off <= 1'b0;
    i_can_engine_model.bits(10, 1'b1, 1'b0);
    chk(may_start, 1'b0);
    i_can_engine_model.bits(1, 1'b1, 1'b0);
    repeat (2) @(posedge core_clk);
    chk(may_start, 1'b1);
    rdx(16'hef00, 2'h2, 16'h0500);
    acc(1'b1, 16'hef00, 2'h1, 16'h000c);
    fork
      i_can_engine_model.burst(3, 4'h0);
      begin
        @(posedge core_clk);
        cs <= 1'b1;
        rd <= 1'b1;
        addr <= 16'hef00;
        byte_en <= 2'h1;
        repeat (6) begin
          @(posedge core_clk);
          exp_q.push_back(16'h000c);
        end
        cs <= 1'b0;
        rd <= 1'b0;
      end
    join
    repeat (6) @(posedge core_clk);
    chk(saw_full, 1'b1);
    chk(evt_ready, 1'b1);
    chk(irq, 1'b0);
    rdx(16'hef00, 2'h2, 16'h1000);
    repeat (4) @(posedge core_clk);
    chk(exp_q.size() == 0, 1'b1);
    chk(i_can_engine_model.stuck, 1'b0);
    test_done();
  end
endmodule // can_control_status_regs_tb_top

bind can_control_status_regs can_control_status_regs_monitor i_can_control_status_regs_monitor (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_cs(i_cs), .i_rd(i_rd), .i_wr(i_wr),
  .i_addr(i_addr), .i_byte_en(i_byte_en), .i_bus_off(i_bus_off), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_init(o_init), .o_may_start(o_may_start), .o_test_bit(o_test_bit),
  .o_bit_timing(o_bit_timing), .o_mask_standard(o_mask_standard));

`default_nettype wire

// ==== testbench/can_engine_model.sv ====
// Purpose: Behavioural protocol engine feeding events and sampled bus bits.
// Assumes: Driven at rising edges; events held until taken.
// Notes: Sets stuck when an event is never taken.
`timescale 1ns/1ns
`default_nettype none

module can_engine_model (
  input wire logic i_core_clk,
  input wire logic i_evt_ready,
  output logic o_evt_valid,
  output logic [can_csr_pkg::EVENT_WIDTH-1:0] o_evt_data,
  output logic o_bit_strobe,
  output logic o_bit_value,
  output logic o_stuff_region
);
  import can_csr_pkg::*;
  logic stuck = 1'b0;
  initial begin
    o_evt_valid = 1'b0;
    o_evt_data = 4'hf;
    o_bit_strobe = 1'b0;
    o_bit_value = 1'b1;
    o_stuff_region = 1'b0;
  end
  // Holds one event word valid until n words have been taken.
  task automatic burst(input int n, input logic [EVENT_WIDTH-1:0] d);
    int k = 0, t = 0;
    @(posedge i_core_clk);
    o_evt_valid <= 1'b1;
    o_evt_data <= d;
    while (k < n && t < 100) begin
      @(posedge i_core_clk);
      t++;
      if (i_evt_ready === 1'b1) k++;
    end
    o_evt_valid <= 1'b0;
    o_evt_data <= ~d;
    if (k < n) stuck = 1'b1;
  endtask
  // The bit line shows the inverse between strobes so no stale level is read.
  task automatic bits(input int n, input logic v, input logic s);
    repeat (n) begin
      @(posedge i_core_clk);
      o_bit_strobe <= 1'b1;
      o_bit_value <= v;
      o_stuff_region <= s;
      @(posedge i_core_clk);
      o_bit_strobe <= 1'b0;
      o_bit_value <= ~v;
    end
  endtask
endmodule // can_engine_model

`default_nettype wire

// ==== verilog/can_control_status_regs.sv ====
// Purpose: Control, status and register window of a CAN 2.0B controller.
// Assumes: Bus access strobes are one cycle long and synchronous to i_core_clk.
// Notes: Message object storage lives outside; only its pending bits come in.
//
// What this block does
// - Registers are 16-bit words in 256-byte window.
// - Byte lanes write and read each half separately.
// - Init set stops new transfers, keeps configuration.
// - Bus-off sets init; software clears it.
// - After init clears, wait 11 recessive bits.
// - Global enable gates interrupt line only.
// - Status enable raises cause on outcomes, errors.
// - Error enable raises cause on warning/bus-off change.
// - Bit timing writable only when unlock set.
// - Clean transfer clears error code; 7 unused.
// - Error code encoding zero through six.
// - Over five equal stuffed bits is stuff error.
// - Transmit success flag set by hardware, CPU-cleared.
// - Receive success flag set by hardware, CPU-cleared.
// - Warning flag when an error counter reaches 96.
// - Bus-off flag follows bus-off state.
// - Upper status byte read clears status cause.
// - Status byte writes never create or remove cause.
// - Interrupt line while cause nonzero and enabled.
`timescale 1ns/1ns
`default_nettype none

module can_control_status_regs (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [1:0] i_byte_en,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_evt_valid,
  output logic o_evt_ready,
  input wire logic [can_csr_pkg::EVENT_WIDTH-1:0] i_evt_data,
  input wire logic i_bit_strobe,
  input wire logic i_bit_value,
  input wire logic i_stuff_region,
  input wire logic [7:0] i_tx_err_count,
  input wire logic [7:0] i_rx_err_count,
  input wire logic i_bus_off,
  input wire logic [can_csr_pkg::MSG_OBJECTS-1:0] i_msg_irq_pending,
  output logic o_irq,
  output logic o_init,
  output logic o_may_start,
  output logic o_test_bit,
  output logic [15:0] o_bit_timing,
  output logic [15:0] o_mask_standard,
  output logic [31:0] o_mask_extended,
  output logic [31:0] o_mask_final
);
  import can_csr_pkg::*;

  // ==========================================================================
  // Bus decode
  typedef enum logic [1:0] {
    LINK_OFFLINE = 2'b00,
    LINK_WAIT_IDLE = 2'b01,
    LINK_ACTIVE = 2'b10
  } link_state_type;

  logic in_window, wr_csr, rd_csr, wr_bt, wr_gms, wr_gme_lo, wr_gme_hi, wr_fom_lo, wr_fom_hi;
  logic status_read;
  logic [15:0] word_addr;

  assign word_addr = {i_addr[15:1], 1'b0};
  assign in_window = i_cs && (word_addr[15:8] == WINDOW_BASE[15:8]);
  assign wr_csr = in_window && i_wr && (word_addr == ADDR_CONTROL_AND_STATUS);
  assign rd_csr = in_window && i_rd && (word_addr == ADDR_CONTROL_AND_STATUS);
  assign status_read = rd_csr && i_byte_en[1];
  assign wr_bt = in_window && i_wr && (word_addr == ADDR_BIT_TIMING);
  assign wr_gms = in_window && i_wr && (word_addr == ADDR_GLOBAL_MASK_STANDARD);
  assign wr_gme_lo = in_window && i_wr && (word_addr == ADDR_GLOBAL_MASK_EXTENDED);
  assign wr_gme_hi = in_window && i_wr && (word_addr == ADDR_GLOBAL_MASK_EXTENDED + WORD_STEP);
  assign wr_fom_lo = in_window && i_wr && (word_addr == ADDR_FINAL_OBJECT_MASK);
  assign wr_fom_hi = in_window && i_wr && (word_addr == ADDR_FINAL_OBJECT_MASK + WORD_STEP);

  function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] be);
    lane_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // ==========================================================================
  // Event buffer between the protocol engine and the status fields
  // Event word: bit 3 set for a transmit outcome, bits 2:0 the error code (0 = success).
  // Draining stalls during a control register read so the read sees a stable snapshot.
  logic evt_valid, evt_take;
  logic [EVENT_WIDTH-1:0] evt_data;

  assign evt_take = evt_valid && !rd_csr;

  can_event_buffer #(.WIDTH(EVENT_WIDTH), .DEPTH(EVENT_DEPTH)) u_event_buffer (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_in_valid(i_evt_valid),
    .o_in_ready(o_evt_ready),
    .i_in_data(i_evt_data),
    .o_out_valid(evt_valid),
    .i_out_ready(!rd_csr),
    .o_out_data(evt_data)
  );

  // ==========================================================================
  // Stuff checker and bus-off recovery
  link_state_type link_reg, link_next;
  logic [3:0] run_reg, run_next;
  logic [2:0] same_reg, same_next;
  logic last_bit_reg, last_bit_next;
  logic stuff_error, recovery_step;
  logic init_reg;

  always_comb begin
    link_next = link_reg;
    run_next = run_reg;
    same_next = same_reg;
    last_bit_next = last_bit_reg;
    stuff_error = 1'b0;
    recovery_step = 1'b0;
    if (i_bit_strobe) begin
      last_bit_next = i_bit_value;
      if (!i_stuff_region || i_bit_value != last_bit_reg) begin
        same_next = 3'h1;
      end else if (same_reg == STUFF_LIMIT) begin
        stuff_error = 1'b1;
        same_next = 3'h1;
      end else begin
        same_next = 3'(same_reg + 1'b1);
      end
    end
    case (link_reg)
      LINK_OFFLINE: begin
        run_next = '0;
        if (!init_reg) begin
          link_next = LINK_WAIT_IDLE;
        end
      end
      LINK_WAIT_IDLE: begin
        if (init_reg) begin
          link_next = LINK_OFFLINE;
        end else if (i_bit_strobe) begin
          if (!i_bit_value) begin
            run_next = '0;
          end else if (run_reg == RECESSIVE_RUN - 1'b1) begin
            run_next = '0;
            if (i_bus_off) begin
              recovery_step = 1'b1;
            end else begin
              link_next = LINK_ACTIVE;
            end
          end else begin
            run_next = 4'(run_reg + 1'b1);
          end
        end
      end
      LINK_ACTIVE: begin
        if (init_reg) begin
          link_next = LINK_OFFLINE;
        end
      end
      default: link_next = LINK_OFFLINE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_reg <= LINK_OFFLINE;
      run_reg <= '0;
      same_reg <= 3'h1;
      last_bit_reg <= 1'b1;
    end else begin
      link_reg <= link_next;
      run_reg <= run_next;
      same_reg <= same_next;
      last_bit_reg <= last_bit_next;
    end
  end

  assign o_may_start = (link_reg == LINK_ACTIVE) && !init_reg;

  // ==========================================================================
  // Control and status register
  logic ie_reg, ie_next, sie_reg, sie_next, eie_reg, eie_next, cce_reg, cce_next;
  logic tst_reg, tst_next, init_next, tx_success_flag_reg, tx_success_flag_next, rx_success_flag_reg, rx_success_flag_next;
  logic warn_reg, warn_next, bus_off_flag_reg, bus_off_flag_next, pend_reg, pend_next;
  logic [2:0] lec_reg, lec_next;
  logic [15:0] csr_view, csr_wr;
  logic status_event;

  assign csr_view = {bus_off_flag_reg, warn_reg, 1'b0, rx_success_flag_reg, tx_success_flag_reg, lec_reg,
                     tst_reg, cce_reg, 2'b00, eie_reg, sie_reg, ie_reg, init_reg};
  assign csr_wr = lane_merge(csr_view, i_wdata, i_byte_en);

  always_comb begin
    init_next = init_reg;
    ie_next = ie_reg;
    sie_next = sie_reg;
    eie_next = eie_reg;
    cce_next = cce_reg;
    tst_next = tst_reg;
    tx_success_flag_next = tx_success_flag_reg;
    rx_success_flag_next = rx_success_flag_reg;
    lec_next = lec_reg;
    pend_next = pend_reg;
    status_event = 1'b0;
    warn_next = (i_tx_err_count >= WARNING_LIMIT) || (i_rx_err_count >= WARNING_LIMIT);
    bus_off_flag_next = i_bus_off;
    if (wr_csr) begin
      init_next = csr_wr[BIT_INIT];
      ie_next = csr_wr[BIT_GLOBAL_IRQ_ENABLE];
      sie_next = csr_wr[BIT_STATUS_CHANGE_IRQ_ENABLE];
      eie_next = csr_wr[BIT_ERROR_IRQ_ENABLE];
      cce_next = csr_wr[BIT_TIMING_WRITE_UNLOCK];
      tst_next = csr_wr[BIT_TEST];
      tx_success_flag_next = csr_wr[BIT_TX_SUCCESS];
      rx_success_flag_next = csr_wr[BIT_RX_SUCCESS];
      lec_next = csr_wr[LEC_LSB +: 3];
    end
    if (!bus_off_flag_reg && i_bus_off) begin
      init_next = 1'b1;
    end
    if (evt_take) begin
      status_event = 1'b1;
      lec_next = evt_data[2:0];
      if (evt_data[2:0] == LEC_NONE) begin
        lec_next = LEC_NONE;
        if (evt_data[3]) begin
          tx_success_flag_next = 1'b1;
        end else begin
          rx_success_flag_next = 1'b1;
        end
      end
    end else if (stuff_error) begin
      status_event = 1'b1;
      lec_next = LEC_STUFF;
    end else if (recovery_step) begin
      status_event = 1'b1;
      lec_next = LEC_BIT0;
    end
    if (status_read) begin
      pend_next = 1'b0;
    end
    if (sie_reg && status_event) begin
      pend_next = 1'b1;
    end
    if (eie_reg && ((warn_next != warn_reg) || (bus_off_flag_next != bus_off_flag_reg))) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_reg <= CSR_RESET[BIT_INIT];
      ie_reg <= CSR_RESET[BIT_GLOBAL_IRQ_ENABLE];
      sie_reg <= CSR_RESET[BIT_STATUS_CHANGE_IRQ_ENABLE];
      eie_reg <= CSR_RESET[BIT_ERROR_IRQ_ENABLE];
      cce_reg <= CSR_RESET[BIT_TIMING_WRITE_UNLOCK];
      tst_reg <= CSR_RESET[BIT_TEST];
      tx_success_flag_reg <= CSR_RESET[BIT_TX_SUCCESS];
      rx_success_flag_reg <= CSR_RESET[BIT_RX_SUCCESS];
      lec_reg <= CSR_RESET[LEC_LSB +: 3];
      warn_reg <= CSR_RESET[BIT_ERROR_WARNING];
      bus_off_flag_reg <= CSR_RESET[BIT_BUS_OFF];
      pend_reg <= 1'b0;
    end else begin
      init_reg <= init_next;
      ie_reg <= ie_next;
      sie_reg <= sie_next;
      eie_reg <= eie_next;
      cce_reg <= cce_next;
      tst_reg <= tst_next;
      tx_success_flag_reg <= tx_success_flag_next;
      rx_success_flag_reg <= rx_success_flag_next;
      lec_reg <= lec_next;
      warn_reg <= warn_next;
      bus_off_flag_reg <= bus_off_flag_next;
      pend_reg <= pend_next;
    end
  end

  assign o_init = init_reg;
  assign o_test_bit = tst_reg;

  // ==========================================================================
  // Interrupt cause identifier
  logic [7:0] cause_id;

  always_comb begin
    cause_id = IRQ_ID_IDLE;
    for (int n = MSG_OBJECTS - 1; n >= 1; n--) begin
      if (i_msg_irq_pending[n-1]) begin
        cause_id = 8'(IRQ_ID_OBJECT_BASE + 8'(n));
      end
    end
    if (i_msg_irq_pending[MSG_OBJECTS-1]) begin
      cause_id = IRQ_ID_LAST_OBJECT;
    end
    if (pend_reg) begin
      cause_id = IRQ_ID_STATUS;
    end
  end

  assign o_irq = ie_reg && (cause_id != IRQ_ID_IDLE);

  // ==========================================================================
  // Configuration registers and read port
  logic [15:0] bt_reg, bt_next, gms_reg, gms_next, rdata_reg, rdata_next;
  logic [31:0] gme_reg, gme_next, fom_reg, fom_next;
  logic rvalid_reg, rvalid_next;

  always_comb begin
    bt_next = bt_reg;
    gms_next = gms_reg;
    gme_next = gme_reg;
    fom_next = fom_reg;
    if (wr_bt && cce_reg) begin
      bt_next = lane_merge(bt_reg, i_wdata, i_byte_en);
    end
    if (wr_gms) begin
      gms_next = lane_merge(gms_reg, i_wdata, i_byte_en);
    end
    if (wr_gme_lo) begin
      gme_next[15:0] = lane_merge(gme_reg[15:0], i_wdata, i_byte_en);
    end
    if (wr_gme_hi) begin
      gme_next[31:16] = lane_merge(gme_reg[31:16], i_wdata, i_byte_en);
    end
    if (wr_fom_lo) begin
      fom_next[15:0] = lane_merge(fom_reg[15:0], i_wdata, i_byte_en);
    end
    if (wr_fom_hi) begin
      fom_next[31:16] = lane_merge(fom_reg[31:16], i_wdata, i_byte_en);
    end
    rvalid_next = in_window && i_rd;
    rdata_next = 16'h0000;
    if (in_window && i_rd) begin
      case (word_addr)
        ADDR_CONTROL_AND_STATUS: rdata_next = csr_view;
        ADDR_INTERRUPT_CAUSE: rdata_next = {8'h00, cause_id};
        ADDR_BIT_TIMING: rdata_next = cce_reg ? bt_reg : 16'h0000;
        ADDR_GLOBAL_MASK_STANDARD: rdata_next = gms_reg;
        ADDR_GLOBAL_MASK_EXTENDED: rdata_next = gme_reg[15:0];
        ADDR_GLOBAL_MASK_EXTENDED + WORD_STEP: rdata_next = gme_reg[31:16];
        ADDR_FINAL_OBJECT_MASK: rdata_next = fom_reg[15:0];
        ADDR_FINAL_OBJECT_MASK + WORD_STEP: rdata_next = fom_reg[31:16];
        default: rdata_next = 16'h0000;
      endcase
      rdata_next = {i_byte_en[1] ? rdata_next[15:8] : 8'h00,
                    i_byte_en[0] ? rdata_next[7:0] : 8'h00};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bt_reg <= BIT_TIMING_RESET;
      gms_reg <= MASK_RESET[15:0];
      gme_reg <= MASK_RESET;
      fom_reg <= MASK_RESET;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      bt_reg <= bt_next;
      gms_reg <= gms_next;
      gme_reg <= gme_next;
      fom_reg <= fom_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_bit_timing = bt_reg;
  assign o_mask_standard = gms_reg;
  assign o_mask_extended = gme_reg;
  assign o_mask_final = fom_reg;

endmodule // can_control_status_regs

`default_nettype wire

// ==== verilog/can_event_buffer.sv ====
// Purpose: Two-entry buffer for transfer outcome events.
// Assumes: Single clock, asynchronous active low reset.
// Notes: Full and empty are exact; the source sees ready low when full.
`timescale 1ns/1ns
`default_nettype none

module can_event_buffer #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PW:0] count_reg, count_next;
  logic push, pop;

  assign o_in_ready = (count_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
    end
    if (push && !pop) begin
      count_next = (PW+1)'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = (PW+1)'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

endmodule // can_event_buffer

`default_nettype wire
